// >>> common/frame_store_defines.vh
// Constants for the masked plane frame store writer.
// Assumes a 32-bit big-endian system bus word: byte 0 is data[31:24].
`ifndef FRAME_STORE_DEFINES_VH
`define FRAME_STORE_DEFINES_VH

// Address decode fields
`define SEL_HI          31
`define SEL_LO          18
`define STORE_REG_BIT   17
`define GEN_PAL_BIT     16
`define STORE_ADDR_HI   16
`define PAL_IDX_HI      9
`define PAL_IDX_LO      2

// General control word byte positions
`define PEN_HI          31
`define PEN_LO          24
`define COL_HI          23
`define COL_LO          16
`define ORG_HI          15
`define ORG_LO          0

// Display origin fields
`define ORG_Y_HI        15
`define ORG_Y_LO        6
`define ORG_X_HI        5
`define ORG_X_LO        0

// Palette entry fields
`define PAL_FLASH       15
`define PAL_B_HI        14
`define PAL_B_LO        10
`define PAL_G_HI        9
`define PAL_G_LO        5
`define PAL_R_HI        4
`define PAL_R_LO        0

// Reset values
`define PEN_RESET       8'h00
`define COL_RESET       8'h00
`define ORG_RESET       16'h0000

// Timing and plane counts
`define BLANK_PIXELS    2'd3
`define H_ACTIVE        512
`define H_TOTAL         640
`define V_ACTIVE        512
`define V_TOTAL         525
`define BASE_PLANES     4

`endif

// >>> dv/bus_master_model.sv
// Behavioural system bus master: one write or read at a time.
// Assumes a registered ack that answers within a few cycles.
module bus_master_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  output logic      [31:0] addr_o  = 32'h0000_0000,
  output logic      [31:0] wdata_o = 32'h0000_0000,
  output logic      [3:0]  be_o    = 4'h0,
  output logic             write_o = 1'b0,
  output logic             read_o  = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [3:0] b,
                      output logic ok);
    int n;
    // Two edges of gap keep the spacing after the previous ack
    repeat (2) @(posedge clk_i);
    #1 addr_o = a;
    wdata_o = d;
    be_o = b;
    write_o = wr;
    read_o = !wr;
    n = 0;
    ok = 1'b0;
    while (ok !== 1'b1 && n < 8) begin
      @(posedge clk_i);
      ok = ack_i;
      n++;
    end
    // Released lines show the inverse, not a stale copy
    #1 write_o = 1'b0;
    read_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
    be_o = ~b;
  endtask
endmodule

// >>> dv/fsw_checker.sv
// Port checker for the frame store writer: bus handshake and raster pulses.
// Assumes one clock domain and a master that holds its request until ack.
module fsw_checker #(
  parameter H_TOTAL = 640,
  parameter V_TOTAL = 525
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [31:0] addr_i,
  input wire logic [3:0]  byte_en_i,
  input wire logic        write_i,
  input wire logic        read_i,
  input wire logic [15:0] board_switch_i,
  input wire logic        palette_fitted_i,
  input wire logic        ack_o,
  input wire logic [4:0]  red_o,
  input wire logic [4:0]  green_o,
  input wire logic [4:0]  blue_o,
  input wire logic        field_start_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int   cnt_r;
  logic seen_r;
  wire  sel  = board_switch_i[1:0] == 2'b00 && addr_i[31:18] == board_switch_i[15:2];
  wire  both = |byte_en_i[3:2] && |byte_en_i[1:0];
  wire  req  = write_i || read_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // First pulse after reset has no reference point
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r  <= 0;
      seen_r <= 1'b0;
    end else if (field_start_o) begin
      cnt_r  <= 0;
      seen_r <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 1;
    end
  end
  ack_one_cycle_a: assert property (ack_o |=> !ack_o) else $error("ack wider than one cycle");
  ack_selected_a: assert property (ack_o |-> req && sel) else $error("ack without selected request");
  ack_after_take_a: assert property ($rose(ack_o) |-> $past(req, 2)) else $error("ack without taken request");
  short_ack_time_a: assert property (($rose(write_i) || $rose(read_i)) && sel && (read_i || addr_i[17] || !both)
    |=> !ack_o ##1 ack_o) else $error("single cycle access ack late");
  store_ack_time_a: assert property ($rose(write_i) && sel && !addr_i[17] && both
    |=> !ack_o [*2] ##1 ack_o) else $error("two half store ack wrong");
  unsel_silent_a: assert property (req && !sel |=> !ack_o) else $error("unselected access acked");
  field_pulse_a: assert property (field_start_o |=> !field_start_o) else $error("field pulse too wide");
  field_period_a: assert property (field_start_o && seen_r |-> cnt_r == H_TOTAL * V_TOTAL - 1)
    else $error("field period wrong");
  pal_write_blank_a: assert property (ack_o && write_i && sel && addr_i[17:16] == 2'b11 && palette_fitted_i
    |=> (red_o == 5'h00 && green_o == 5'h00 && blue_o == 5'h00) [*3]) else $error("no blank on palette write");
endmodule

// >>> dv/tb.sv
// Testbench: masked updates, base and palette guns, decode and origin.
// Assumes a shortened raster of 40 by 20 clocks per field.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] BASE = 32'h1230_0000;
  localparam logic [31:0] GEN  = 32'h1232_0000;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        fitted = 1'b0;
  logic [15:0] sw = 16'h1230;
  wire  [31:0] addr, wdata;
  wire  [3:0]  be;
  wire         wr, rd, ack, va, fs;
  wire  [4:0]  r, g, b;
  int          miscompares = 0;
  int          samples_checked = 0;
  logic        ok;
  int          nb = 0;
  initial forever #5 clk_i = ~clk_i;
  bus_master_model m (.clk_i(clk_i), .ack_i(ack), .addr_o(addr), .wdata_o(wdata), .be_o(be), .write_o(wr),
    .read_o(rd));
  frame_store_writer #(.H_ACTIVE(32), .H_TOTAL(40), .V_ACTIVE(16), .V_TOTAL(20)) dut (.clk_i(clk_i),
    .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata), .byte_en_i(be), .write_i(wr), .read_i(rd),
    .board_switch_i(sw), .palette_fitted_i(fitted), .ack_o(ack), .red_o(r), .green_o(g), .blue_o(b),
    .video_active_o(va), .field_start_o(fs));
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic w(logic [31:0] a, logic [31:0] d, logic [3:0] e, logic exp_ack = 1'b1);
    m.xfer(1'b1, a, d, e, ok);
    chk("ack", {31'd0, exp_ack}, {31'd0, ok});
  endtask
  // Waits a whole field so the last write is on screen, then takes pixel (0,0) of the window
  task automatic px(logic [14:0] e);
    int n;
    n = 0;
    repeat (2) begin
      while (fs !== 1'b1 && n < 5000) begin @(negedge clk_i); n++; end
      @(negedge clk_i);
    end
    while (va !== 1'b1 && n < 5000) begin @(negedge clk_i); n++; end
    chk("pixel", {17'd0, e}, {17'd0, r, g, b});
  endtask
  task automatic end_of_test();
    $display("checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #700_000;
    miscompares++;
    end_of_test();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    #1 rst_i = 1'b0;
    w(GEN, 32'h0F01_0000, 4'hF);
    w(BASE, 32'hFFFF_FFFF, 4'hF);
    px(15'h7C00);
    $display("test base colour done");
    w(GEN, 32'h0808_0000, 4'hC);
    w(BASE, 32'hFFFF_FFFF, 4'hF);
    px(15'h03FF);
    $display("test plane protect done");
    w(GEN, 32'h0F00_0000, 4'hC);
    w(BASE, 32'h7FFF_FFFF, 4'hF);
    px(15'h03FF);
    w(BASE, 32'h8000_0000, 4'h8);
    px(15'h0000);
    $display("test mask done");
    m.xfer(1'b0, GEN, 32'hFFFF_FFFF, 4'hF, ok);
    chk("read ack", 32'h0000_0001, {31'd0, ok});
    px(15'h0000);
    #1 sw = 16'h1231;
    w(32'h1231_0000, 32'hFFFF_FFFF, 4'hF, 1'b0);
    #1 sw = 16'h1230;
    w(32'h1234_0000, 32'hFFFF_FFFF, 4'hF, 1'b0);
    px(15'h0000);
    $display("test decode done");
    w(GEN, 32'h0F02_0001, 4'hF);
    w(BASE, 32'h0000_8000, 4'h2);
    px(15'h03E0);
    w(GEN, 32'h0000_0000, 4'h1);
    px(15'h0000);
    $display("test origin done");
    #1 fitted = 1'b1;
    w(GEN, 32'hFF05_0000, 4'hC);
    w(BASE, 32'h8000_0000, 4'h8);
    w(32'h1233_0014, 32'h0000_0E3E, 4'h3);
    px(15'h7A23);
    $display("test palette done");
    w(32'h1233_0014, 32'h0000_8E00, 4'h2);
    repeat (16) begin
      while (fs !== 1'b1) @(negedge clk_i);
      @(negedge clk_i);
      while (va !== 1'b1) @(negedge clk_i);
      if ({r, g, b} === 15'h0000) nb++;
    end
    chk("flash dark fields", 32'd8, nb);
    $display("test flash done");
    end_of_test();
  end
endmodule
bind frame_store_writer fsw_checker #(.H_TOTAL(H_TOTAL), .V_TOTAL(V_TOTAL)) chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .addr_i(addr_i), .byte_en_i(byte_en_i), .write_i(write_i), .read_i(read_i), .board_switch_i(board_switch_i),
  .palette_fitted_i(palette_fitted_i), .ack_o(ack_o), .red_o(red_o), .green_o(green_o), .blue_o(blue_o),
  .field_start_o(field_start_o));

// >>> rtl/frame_store_writer.v
// Write-only frame store board: decode, masked plane update, scan-out.
// Assumes the master holds write_i or read_i until ack_o, then drops it.
// Frame store and colour map hold no reset state.
//
// Behaviour
// RQ1: Square pixel array, 0..1023 each axis
// RQ2: Origin: ten bits top Y, six X/16
// RQ3: First displayed X always multiple of sixteen
// RQ4: Origin bytes writable separately
// RQ5: Displayed window wraps to low indices (Y counts down from origin, wraps past 0 to 1023)
// RQ6: Respond only when 14 address bits match switches
// RQ7: Next bit picks store or control registers
// RQ8: Next bit picks general registers or palette
// RQ9: Palette writes ignored without extension
// RQ10: All locations are write only
// RQ11: Bytes advance X first, then Y
// RQ12: Byte MSB is lowest X pixel
// RQ13: One to four bytes, 16-bit store cycles
// RQ14: Base guns from planes 0-2, plane 3 inverts
// RQ15: Extension: eight plane bits index 256 entries
// RQ16: Entry gives three 5-bit guns, flash bit
// RQ17: Flash at one sixteenth field rate
// RQ18: Palette index lines 9..2, low half used
// RQ19: Palette write blanks video three pixels
// RQ20: Store data is a per-pixel update mask
// RQ21: Plane enable bit protects or permits plane
// RQ22: Colour bits copied into enabled masked planes
// RQ23: General word: enable, colour, origin bytes
// RQ24: Entry layout: flash, blue, green, red
// RQ25: Deselected unless fourth switch digit multiple of four
// RQ26: Master clears store: enables, zero colour, ones
// RQ27: Reads change no contents
`include "frame_store_defines.vh"

module frame_store_writer #(
  parameter PLANES   = 8,
  parameter H_ACTIVE = `H_ACTIVE,
  parameter H_TOTAL  = `H_TOTAL,
  parameter V_ACTIVE = `V_ACTIVE,
  parameter V_TOTAL  = `V_TOTAL
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire [31:0] addr_i,
  input  wire [31:0] wdata_i,
  input  wire [3:0]  byte_en_i,
  input  wire        write_i,
  input  wire        read_i,
  input  wire [15:0] board_switch_i,
  input  wire        palette_fitted_i,
  output reg         ack_o,
  output reg  [4:0]  red_o,
  output reg  [4:0]  green_o,
  output reg  [4:0]  blue_o,
  output reg         video_active_o,
  output reg         field_start_o
);

  localparam [3:0] ST_IDLE  = 4'b0001;
  localparam [3:0] ST_EXEC  = 4'b0010;
  localparam [3:0] ST_HALF1 = 4'b0100;
  localparam [3:0] ST_ACK   = 4'b1000;

  reg [3:0]  state_r;
  reg [3:0]  state_nxt;
  reg [31:0] addr_q_r;
  reg [31:0] data_q_r;
  reg [3:0]  be_q_r;
  reg        wr_q_r;
  reg [7:0]  plane_write_enable_r;
  reg [7:0]  write_colour_bits_r;
  reg [15:0] display_origin_r;
  reg [15:0] palette_entry [0:255];
  reg [1:0]  blank_cnt_r;
  reg [9:0]  hx_r;
  reg [9:0]  vy_r;
  reg [3:0]  field_cnt_r;
  reg [7:0]  px_r;
  reg        act_r;
  reg        fstart_r;
  reg [9:0]  hx_nxt;
  reg [9:0]  vy_nxt;
  reg [3:0]  field_cnt_nxt;
  reg [4:0]  red_nxt;
  reg [4:0]  green_nxt;
  reg [4:0]  blue_nxt;
  reg [1:0]  blank_cnt_nxt;

  wire        selected;
  wire        take;
  wire        is_store;
  wire        is_gen;
  wire        is_pal;
  wire        hi_half;
  wire        lo_half;
  wire        do_hi;
  wire        do_lo;
  wire [15:0] hi_mask;
  wire [15:0] lo_mask;
  wire [15:0] st_idx;
  wire [15:0] st_mask;
  wire [9:0]  fx;
  wire [9:0]  fy;
  wire [15:0] scan_idx;
  wire [3:0]  scan_bit;
  wire [7:0]  scan_px;
  wire        h_end;
  wire        v_end;
  wire [15:0] pal_q;
  wire        sel_digit_ok;
  wire        sel_match;
  wire        req_any;
  wire        st_exec;
  wire        st_half1;
  wire        gen_go;
  wire        pal_go;
  wire        pen_we;
  wire        col_we;
  wire        org_hi_we;
  wire        org_lo_we;
  wire        pal_hi_we;
  wire        pal_lo_we;
  wire [7:0]  pal_idx;
  wire        blanking;
  wire [15:0] hi_lane;
  wire [15:0] lo_lane;

  // Switch low digit bits 1:0 must be zero for the board to answer at all
  assign sel_digit_ok = (board_switch_i[1:0] == 2'b00);                   // see RQ25
  assign sel_match    = (addr_i[`SEL_HI:`SEL_LO] == board_switch_i[15:2]); // see RQ6
  // An unselected request is never acknowledged; the master must give up
  assign selected     = sel_digit_ok && sel_match;
  assign req_any      = write_i || read_i;
  assign take         = (state_r == ST_IDLE) && req_any && selected;
  assign st_exec      = (state_r == ST_EXEC);
  assign st_half1     = (state_r == ST_HALF1);

  assign is_store = wr_q_r && !addr_q_r[`STORE_REG_BIT];               // see RQ7
  assign is_gen   = wr_q_r && addr_q_r[`STORE_REG_BIT] && !addr_q_r[`GEN_PAL_BIT]; // see RQ8
  assign is_pal   = wr_q_r && addr_q_r[`STORE_REG_BIT] && addr_q_r[`GEN_PAL_BIT]
                    && palette_fitted_i;                               // see RQ9

  // Big-endian lanes: byte 0 (lowest address) sits in data[31:24]
  assign hi_half = |be_q_r[3:2];
  assign lo_half = |be_q_r[1:0];
  assign hi_lane = {{8{be_q_r[3]}}, {8{be_q_r[2]}}};
  assign lo_lane = {{8{be_q_r[1]}}, {8{be_q_r[0]}}};
  assign hi_mask = data_q_r[31:16] & hi_lane;
  assign lo_mask = data_q_r[15:0] & lo_lane;

  // Upper halfword first; a full word needs a second store cycle
  assign do_hi   = is_store && st_exec && hi_half;                     // see RQ13
  assign do_lo   = is_store && ((st_exec && !hi_half && lo_half) ||
                                st_half1);                             // see RQ13
  // Halfword index is {y, x/16}: X advances first, then Y
  assign st_idx  = {addr_q_r[`STORE_ADDR_HI:2], !do_hi};               // see RQ11
  assign st_mask = do_hi ? hi_mask : lo_mask;

  // Register and palette lanes act once, in the execute state
  assign gen_go    = is_gen && st_exec;                                // see RQ8
  assign pal_go    = is_pal && st_exec;                                // see RQ9
  assign pen_we    = gen_go && be_q_r[3];                              // see RQ23
  assign col_we    = gen_go && be_q_r[2];                              // see RQ23
  assign org_hi_we = gen_go && be_q_r[1];                              // see RQ4
  assign org_lo_we = gen_go && be_q_r[0];                              // see RQ4
  // Bytes 0 and 1 of a palette slot have no storage behind them
  assign pal_hi_we = pal_go && be_q_r[1];                              // see RQ18
  assign pal_lo_we = pal_go && be_q_r[0];                              // see RQ18
  assign pal_idx   = addr_q_r[`PAL_IDX_HI:`PAL_IDX_LO];                // see RQ18

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:  begin
        if (take)
          state_nxt = ST_EXEC;
      end
      ST_EXEC:  begin
        if (is_store && hi_half && lo_half)
          state_nxt = ST_HALF1;                                        // see RQ13
        else
          state_nxt = ST_ACK;
      end
      ST_HALF1: state_nxt = ST_ACK;
      ST_ACK:   state_nxt = ST_IDLE;
      default:  state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      ack_o   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ack_o   <= (state_nxt == ST_ACK);
    end
  end

  // Request is latched once, so the bus is free to change after the ack
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      addr_q_r <= 32'h0000_0000;
      data_q_r <= 32'h0000_0000;
      be_q_r   <= 4'h0;
      wr_q_r   <= 1'b0;
    end else if (take) begin
      addr_q_r <= addr_i;
      data_q_r <= wdata_i;
      be_q_r   <= byte_en_i;
      // A read is acknowledged but carries no write effect
      wr_q_r   <= write_i;                                             // see RQ10 RQ27
    end
  end

  // General control word: enable, colour, then the origin half
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      plane_write_enable_r <= `PEN_RESET;
      write_colour_bits_r  <= `COL_RESET;
      display_origin_r     <= `ORG_RESET;
    end else if (gen_go) begin
      if (pen_we)
        plane_write_enable_r <= data_q_r[`PEN_HI:`PEN_LO];             // see RQ23 RQ21
      if (col_we)
        write_colour_bits_r <= data_q_r[`COL_HI:`COL_LO];              // see RQ23
      if (org_hi_we)
        display_origin_r[15:8] <= data_q_r[15:8];                      // see RQ4 RQ2
      if (org_lo_we)
        display_origin_r[7:0] <= data_q_r[7:0];                        // see RQ4
    end
  end

  // Palette: upper half of the 32-bit slot is ignored
  // No reset on the colour map; entries show unknown until written
  always @(posedge clk_i) begin
    if (pal_hi_we)
      palette_entry[pal_idx][15:8] <= data_q_r[15:8];                  // see RQ18
    if (pal_lo_we)
      palette_entry[pal_idx][7:0] <= data_q_r[7:0];                    // see RQ18
  end

  // Scan position mapped into the store, wrapping at 1024 on both axes
  // A new origin applies from the next pixel, so mid-field writes tear
  assign fx       = {display_origin_r[`ORG_X_HI:`ORG_X_LO], 4'h0} + hx_r;  // see RQ3 RQ5
  assign fy       = display_origin_r[`ORG_Y_HI:`ORG_Y_LO] - vy_r;          // see RQ2 RQ5
  assign scan_idx = {fy, fx[9:4]};                                         // see RQ1
  // Lowest X of a halfword is its most significant bit
  assign scan_bit = 4'hF - fx[3:0];                                        // see RQ12

  // Plane memories are not reset: clear the store before showing it
  genvar p;
  generate
    for (p = 0; p < PLANES; p = p + 1) begin : g_plane
      reg  [15:0] plane_mem [0:65535];
      wire        plane_on;
      // Planes beyond the base four exist only with the extension
      assign plane_on = plane_write_enable_r[p] &&
                        ((p < `BASE_PLANES) || palette_fitted_i);        // see RQ21
      always @(posedge clk_i) begin
        if ((do_hi || do_lo) && plane_on) begin
          // Mask bit 1 takes the colour bit; mask bit 0 keeps the pixel
          if (write_colour_bits_r[p])
            plane_mem[st_idx] <= plane_mem[st_idx] | st_mask;            // see RQ20 RQ22
          else
            plane_mem[st_idx] <= plane_mem[st_idx] & ~st_mask;           // see RQ20 RQ22
        end
      end
      assign scan_px[p] = plane_mem[scan_idx][scan_bit] &&
                          ((p < `BASE_PLANES) || palette_fitted_i);
    end
  endgenerate

  assign h_end = (hx_r == H_TOTAL - 1);
  assign v_end = (vy_r == V_TOTAL - 1);
  assign pal_q = palette_entry[px_r];                                  // see RQ15

  // Wrap at the end of each line and field
  always @* begin
    hx_nxt        = hx_r + 10'h001;
    vy_nxt        = vy_r;
    field_cnt_nxt = field_cnt_r;
    if (h_end) begin
      hx_nxt = 10'h000;
      if (v_end) begin
        vy_nxt        = 10'h000;
        // Bit 3 toggles every eight fields: a sixteen-field flash cycle
        field_cnt_nxt = field_cnt_r + 4'h1;                            // see RQ17
      end else begin
        vy_nxt = vy_r + 10'h001;
      end
    end
  end

  // Raster counters, one pixel per clock
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hx_r        <= 10'h000;
      vy_r        <= 10'h000;
      field_cnt_r <= 4'h0;
    end else begin
      hx_r        <= hx_nxt;
      vy_r        <= vy_nxt;
      field_cnt_r <= field_cnt_nxt;
    end
  end

  // One stage of plane fetch, so guns lag the counters by two clocks
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      px_r     <= 8'h00;
      act_r    <= 1'b0;
      fstart_r <= 1'b0;
    end else begin
      px_r     <= scan_px;
      act_r    <= (hx_r < H_ACTIVE) && (vy_r < V_ACTIVE);
      fstart_r <= h_end && v_end;
    end
  end

  // Blank hides a palette entry in mid-change
  always @* begin
    blank_cnt_nxt = blank_cnt_r;
    if (pal_go)
      blank_cnt_nxt = `BLANK_PIXELS;                                   // see RQ19
    else if (blanking)
      blank_cnt_nxt = blank_cnt_r - 2'h1;
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i)
      blank_cnt_r <= 2'h0;
    else
      blank_cnt_r <= blank_cnt_nxt;
  end

  assign blanking = (blank_cnt_r != 2'h0);                             // see RQ19

  always @* begin
    red_nxt   = 5'h00;
    green_nxt = 5'h00;
    blue_nxt  = 5'h00;
    if (act_r && !blanking) begin                                      // see RQ19
      if (palette_fitted_i) begin
        // Flashing entries show black for half of each 16-field period
        if (!(pal_q[`PAL_FLASH] && field_cnt_r[3])) begin              // see RQ17 RQ16
          red_nxt   = pal_q[`PAL_R_HI:`PAL_R_LO];                      // see RQ24 RQ16
          green_nxt = pal_q[`PAL_G_HI:`PAL_G_LO];                      // see RQ24
          blue_nxt  = pal_q[`PAL_B_HI:`PAL_B_LO];                      // see RQ24
        end
      end else begin
        // TTL guns drive full scale; plane 3 inverts the sense
        red_nxt   = {5{px_r[0] ^ px_r[3]}};                            // see RQ14
        green_nxt = {5{px_r[1] ^ px_r[3]}};                            // see RQ14
        blue_nxt  = {5{px_r[2] ^ px_r[3]}};                            // see RQ14
      end
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      red_o          <= 5'h00;
      green_o        <= 5'h00;
      blue_o         <= 5'h00;
      video_active_o <= 1'b0;
      field_start_o  <= 1'b0;
    end else begin
      red_o          <= red_nxt;
      green_o        <= green_nxt;
      blue_o         <= blue_nxt;
      video_active_o <= act_r;
      field_start_o  <= fstart_r;
    end
  end

endmodule
